// file: core/srw_defines.svh
// Timing and reset constants for the supervisor reset watchdog
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH
`define SRW_CLK_PERIOD_NS 100
`define SRW_NS_PER_MS 1000000
`define SRW_STRETCH_MS 200
`define SRW_WD_TIMEOUT_MS 1600
`define SRW_STRETCH_CYC ((`SRW_STRETCH_MS * `SRW_NS_PER_MS) / `SRW_CLK_PERIOD_NS)
`define SRW_WD_CYC ((`SRW_WD_TIMEOUT_MS * `SRW_NS_PER_MS) / `SRW_CLK_PERIOD_NS)
`define SRW_STRETCH_W 21
`define SRW_WD_W 24
`define SRW_IN_W 5
`define SRW_IN_RST 5'h01
`endif

// file: core/srw_pkg.sv
// Types shared by the supervisor reset watchdog
`include "srw_defines.svh"
package srw_pkg;
  typedef struct packed {
    logic sense_below;
    logic kick_float;
    logic kick;
    logic manual_reset_n;
    logic supply_low;
  } srw_in_s;

  typedef enum logic [1:0] {
    SRW_HOLD,
    SRW_STRETCH,
    SRW_RUN
  } srw_rst_e;

  typedef struct packed {
    srw_rst_e rst_st;
    logic [`SRW_STRETCH_W-1:0] stretch_cnt;
    logic [`SRW_WD_W-1:0] wd_cnt;
    logic wd_expired;
    logic kick_prev;
    logic reset_n;
    logic reset;
    logic expired_n;
    logic fail_n;
  } srw_state_s;
endpackage

// file: core/srw_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`include "srw_defines.svh"
module srw_sync #(
  parameter int W = `SRW_IN_W,
  parameter logic [W-1:0] RST_VAL = `SRW_IN_RST
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } srw_sync_s;

  srw_sync_s st_q;
  srw_sync_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_in; // RL16
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.out[i] = st_q.s3[i]; // RL16
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= {4{RST_VAL}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.out;
endmodule

// file: core/srw_top.sv
// Supervisor: stretched reset, manual reset, watchdog and power-fail flag
`timescale 1ns/100ps
`include "srw_defines.svh"
// What this block does
// RL1: Reset output stays low while the supply-low indication is true.
// RL2: After supply-low clears, reset stays low a further 200 ms.
// RL3: Active-high reset output is always the inverse of the active-low one.
// RL4: Manual reset input low asserts the reset outputs too.
// RL5: Manual reset is debounced by the 200 ms stretch period.
// RL6: After manual reset returns high, reset stays low 200 ms more.
// RL7: No kick transition within 1.6 s drives watchdog expiry output low.
// RL8: Every rising and falling kick edge clears the watchdog timer.
// RL9: Watchdog timer held cleared during reset; timing starts after release.
// RL10: Expiry output stays low until a kick transition, a floating kick or a reset clears the timer.
// RL11: Supply-low forces watchdog expiry output low.
// RL12: Floating kick disables the watchdog; expiry then follows supply-low only.
// RL13: A watchdog timeout never asserts reset by itself.
// RL14: Power-fail output low while sensed level is below the reference.
// RL15: Processor must toggle the kick line at least every 1.6 s.
// RL16: Analog results arrive synchronised; periods are parameterised cycle counts.
module srw_top #(
  parameter int STRETCH_CYC = `SRW_STRETCH_CYC,
  parameter int WD_CYC = `SRW_WD_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic kick_float_in,
  input wire logic supply_sense_below_in,
  output logic reset_n,
  output logic reset,
  output logic watchdog_expired_n,
  output logic supply_fail_n
);
  localparam logic [`SRW_STRETCH_W-1:0] STRETCH_LAST = `SRW_STRETCH_W'(STRETCH_CYC - 1);
  localparam logic [`SRW_WD_W-1:0] WD_LAST = `SRW_WD_W'(WD_CYC - 1);

  srw_pkg::srw_in_s raw_in;
  srw_pkg::srw_in_s in_s;
  srw_pkg::srw_state_s st_q;
  srw_pkg::srw_state_s st_d;
  logic hold_req;
  logic kick_edge;
  logic wd_clear;
  logic reset_now;

  assign raw_in.sense_below = supply_sense_below_in;
  assign raw_in.kick_float = kick_float_in;
  assign raw_in.kick = watchdog_kick_in;
  assign raw_in.manual_reset_n = manual_reset_n;
  assign raw_in.supply_low = supply_low_in;

  srw_sync #(
    .W(`SRW_IN_W),
    .RST_VAL(`SRW_IN_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(in_s)
  );

  // Either source holds reset; release waits for the full stretch
  assign hold_req = in_s.supply_low | ~in_s.manual_reset_n; // RL1 RL4
  assign kick_edge = in_s.kick ^ st_q.kick_prev;

  always_comb
  begin
    st_d = st_q;
    st_d.kick_prev = in_s.kick;
    reset_now = 1'b1;
    unique case (st_q.rst_st)
      srw_pkg::SRW_HOLD:
      begin
        st_d.stretch_cnt = '0;
        if (!hold_req)
        begin
          st_d.rst_st = srw_pkg::SRW_STRETCH;
        end
      end
      srw_pkg::SRW_STRETCH:
      begin
        // Any bounce back low restarts the whole stretch
        if (hold_req)
        begin
          st_d.rst_st = srw_pkg::SRW_HOLD; // RL5
          st_d.stretch_cnt = '0;
        end
        else if (st_q.stretch_cnt == STRETCH_LAST)
        begin
          st_d.rst_st = srw_pkg::SRW_RUN; // RL2 RL6
          reset_now = 1'b0;
        end
        else
        begin
          st_d.stretch_cnt = st_q.stretch_cnt + 1'b1;
        end
      end
      srw_pkg::SRW_RUN:
      begin
        // Watchdog state plays no part in leaving this state
        if (hold_req)
        begin
          st_d.rst_st = srw_pkg::SRW_HOLD; // RL13
          st_d.stretch_cnt = '0;
        end
        else
        begin
          reset_now = 1'b0;
        end
      end
    endcase
    st_d.reset_n = ~reset_now;
    st_d.reset = reset_now; // RL3
    wd_clear = ~st_q.reset_n | in_s.kick_float | kick_edge; // RL8 RL9 RL12
    if (wd_clear)
    begin
      st_d.wd_cnt = '0;
      st_d.wd_expired = 1'b0;
    end
    else if (st_q.wd_cnt == WD_LAST)
    begin
      st_d.wd_expired = 1'b1; // RL7 RL10
    end
    else
    begin
      st_d.wd_cnt = st_q.wd_cnt + 1'b1;
    end
    st_d.expired_n = ~(st_d.wd_expired | in_s.supply_low); // RL11
    st_d.fail_n = ~in_s.sense_below; // RL14
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q.rst_st <= srw_pkg::SRW_HOLD;
      st_q.stretch_cnt <= '0;
      st_q.wd_cnt <= '0;
      st_q.wd_expired <= 1'b0;
      st_q.kick_prev <= 1'b0;
      st_q.reset_n <= 1'b0;
      st_q.reset <= 1'b1;
      st_q.expired_n <= 1'b0;
      st_q.fail_n <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reset_n = st_q.reset_n;
  assign reset = st_q.reset;
  assign watchdog_expired_n = st_q.expired_n;
  assign supply_fail_n = st_q.fail_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_supply_hold;
    in_s.supply_low |=> !reset_n;
  endproperty
  a_supply_hold: assert property (p_supply_hold) else $error("released under supply low"); // RL1

  property p_stretch_release;
    $rose(reset_n) |-> $past(st_q.stretch_cnt) == STRETCH_LAST && !$past(hold_req);
  endproperty
  a_stretch_release: assert property (p_stretch_release) else $error("early release"); // RL2

  property p_complement;
    reset == !reset_n;
  endproperty
  a_complement: assert property (p_complement) else $error("outputs not complementary"); // RL3

  property p_manual_hold;
    !in_s.manual_reset_n |=> !reset_n && st_q.stretch_cnt == '0;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual reset not held"); // RL4

  property p_bounce_restart;
    st_q.rst_st == srw_pkg::SRW_STRETCH && hold_req |=> st_q.rst_st == srw_pkg::SRW_HOLD
      ##1 !reset_n;
  endproperty
  a_bounce_restart: assert property (p_bounce_restart) else $error("bounce no restart"); // RL5

  property p_manual_release;
    $rose(in_s.manual_reset_n) && !in_s.supply_low |=> !reset_n [*2];
  endproperty
  a_manual_release: assert property (p_manual_release) else $error("no manual stretch"); // RL6

  property p_timeout;
    st_q.wd_cnt == WD_LAST && !wd_clear |=> !watchdog_expired_n;
  endproperty
  a_timeout: assert property (p_timeout) else $error("watchdog timeout missed"); // RL7

  property p_kick_clear;
    kick_edge |=> st_q.wd_cnt == '0 ##1 watchdog_expired_n || $past(in_s.supply_low);
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear timer"); // RL8

  property p_reset_clear;
    !reset_n |=> st_q.wd_cnt == '0 && !st_q.wd_expired;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("timer ran during reset"); // RL9

  property p_expiry_sticky;
    st_q.wd_expired && !wd_clear |=> st_q.wd_expired && !watchdog_expired_n;
  endproperty
  a_expiry_sticky: assert property (p_expiry_sticky) else $error("expiry dropped early"); // RL10

  property p_low_line;
    in_s.supply_low |=> !watchdog_expired_n;
  endproperty
  a_low_line: assert property (p_low_line) else $error("expiry high under supply low"); // RL11

  property p_float_disable;
    in_s.kick_float |=> !st_q.wd_expired && watchdog_expired_n == !$past(in_s.supply_low);
  endproperty
  a_float_disable: assert property (p_float_disable) else $error("timer active on float"); // RL12

  property p_no_wd_reset;
    reset_n && !hold_req |=> reset_n;
  endproperty
  a_no_wd_reset: assert property (p_no_wd_reset) else $error("reset without a source"); // RL13

  property p_power_fail;
    supply_fail_n == !$past(in_s.sense_below);
  endproperty
  a_power_fail: assert property (p_power_fail) else $error("power-fail output wrong"); // RL14
endmodule

// file: testbench/srw_cpu_model.sv
// Processor model that toggles the watchdog kick line
`timescale 1ns/100ps
module srw_cpu_model #(
  parameter int PERIOD = 30
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic kick_en,
  output logic kick_out
);
  int cnt_q = 0;
  initial kick_out = 1'b0;
  // Software stays quiet while held in reset, then kicks well inside the timeout
  always @(posedge sys_clk)
  begin
    if (!kick_en || reset_n !== 1'b1)
      cnt_q <= 0;
    else
    begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      if (cnt_q == 0)
        kick_out <= ~kick_out;
    end
  end
endmodule

// file: testbench/test_supervisor_reset_watchdog.sv
// Self-checking testbench for the supervisor reset watchdog
`timescale 1ns/100ps
`define CHK(g, e) chk(g, e)
module test_supervisor_reset_watchdog;
  localparam int STR = 20;
  localparam int WD = 50;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_low_in = 1'b1;
  logic manual_reset_n = 1'b1;
  logic kick_float_in = 1'b0;
  logic supply_sense_below_in = 1'b0;
  logic kick_en = 1'b0;
  logic watchdog_kick_in, reset_n, reset, watchdog_expired_n, supply_fail_n, v;
  int failures = 0;
  int comparisons = 0;
  int seed = 45451;

  srw_top #(.STRETCH_CYC(STR), .WD_CYC(WD)) srw_top_i (
    .sys_clk(sys_clk), .rst(rst), .supply_low_in(supply_low_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .kick_float_in(kick_float_in), .supply_sense_below_in(supply_sense_below_in),
    .reset_n(reset_n), .reset(reset), .watchdog_expired_n(watchdog_expired_n),
    .supply_fail_n(supply_fail_n));

  srw_cpu_model #(.PERIOD(30)) srw_cpu_model_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .kick_en(kick_en), .kick_out(watchdog_kick_in));

  always #50 sys_clk = ~sys_clk;

  task chk(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Power-fail output is the inverse of the below-reference result
  function automatic logic fail_level(input logic below);
    return ~below;
  endfunction

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Outputs are looked at mid-cycle, once the edge has settled
  task look(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task wait_rel;
    for (int i = 0; i < 200 && reset_n !== 1'b1; i++)
      @(negedge sys_clk);
  endtask

  task done(input string name);
    $display("test %s finished", name);
  endtask

  task close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(negedge sys_clk)
    if (rst === 1'b0) `CHK(reset, ~reset_n);

  initial
  begin
    #(5000 * 100);
    $display("watchdog span ran out at %0t", $time);
    failures++;
    close_out;
  end

  initial
  begin
    wt(6);
    rst <= 1'b0;
    look(10);
    `CHK(reset_n, 1'b0);
    `CHK(watchdog_expired_n, 1'b0);
    wt(1);
    supply_low_in <= 1'b0;
    look(STR);
    `CHK(reset_n, 1'b0);
    look(12);
    `CHK(reset_n, 1'b1);
    `CHK(watchdog_expired_n, 1'b1);
    done("supply");
    wt(1);
    manual_reset_n <= 1'b0;
    look(8);
    `CHK(reset_n, 1'b0);
    wt(WD + 30);
    for (int i = 0; i < 6; i++)
    begin
      wt(1);
      manual_reset_n <= 1'($random(seed));
    end
    // Release into the stretch, then bounce low long enough to force a restart
    wt(1);
    manual_reset_n <= 1'b1;
    wt(10);
    manual_reset_n <= 1'b0;
    wt(3);
    manual_reset_n <= 1'b1;
    look(STR);
    `CHK(reset_n, 1'b0);
    wait_rel;
    `CHK(reset_n, 1'b1);
    look(WD - 12);
    `CHK(watchdog_expired_n, 1'b1);
    look(20);
    `CHK(watchdog_expired_n, 1'b0);
    `CHK(reset_n, 1'b1);
    look(100);
    `CHK(watchdog_expired_n, 1'b0);
    wt(1);
    kick_en <= 1'b1;
    look(12);
    `CHK(watchdog_expired_n, 1'b1);
    look(200);
    `CHK(watchdog_expired_n, 1'b1);
    done("manual and watchdog");
    wt(1);
    kick_en <= 1'b0;
    kick_float_in <= 1'b1;
    look(WD + 50);
    `CHK(watchdog_expired_n, 1'b1);
    wt(1);
    supply_low_in <= 1'b1;
    look(8);
    `CHK(watchdog_expired_n, 1'b0);
    `CHK(reset_n, 1'b0);
    wt(1);
    supply_low_in <= 1'b0;
    kick_float_in <= 1'b0;
    wait_rel;
    `CHK(reset_n, 1'b1);
    done("floating kick");
    repeat (16)
    begin
      wt(1);
      v = 1'($random(seed));
      supply_sense_below_in <= v;
      look(7);
      `CHK(supply_fail_n, fail_level(v));
    end
    done("power fail");
    close_out;
  end
endmodule
